// >>> hw/status_event_map.vh
`ifndef STATUS_EVENT_MAP_VH
`define STATUS_EVENT_MAP_VH

// Summary byte bit positions
`define SUM_ERRQ_BIT      2
`define SUM_QUES_BIT      3
`define SUM_RESP_BIT      4
`define SUM_EVENT_BIT     5
`define SUM_MASTER_BIT    6
`define SUM_OPER_BIT      7

// Standard event bit positions
`define EVT_DONE_BIT      0
`define EVT_QUERY_BIT     2
`define EVT_DEVICE_BIT    3
`define EVT_EXEC_BIT      4
`define EVT_CMD_BIT       5
`define EVT_PWR_BIT       7
`define EVT_USED_MASK     8'hbd

// Operation condition bit positions
`define OPER_TUNE_BIT     1
`define OPER_ARMED_BIT    5
`define OPER_WAITARM_BIT  6
`define OPER_DATA_BIT     8

// Questionable condition bit position
`define QUES_LOCK_BIT     9

// Error code classes, signed 16-bit
`define ERR_QUERY_LO      (-16'sd499)
`define ERR_QUERY_HI      (-16'sd400)
`define ERR_DEVICE_LO     (-16'sd399)
`define ERR_DEVICE_HI     (-16'sd300)
`define ERR_EXEC_LO       (-16'sd299)
`define ERR_EXEC_HI       (-16'sd200)
`define ERR_CMD_LO        (-16'sd199)
`define ERR_CMD_HI        (-16'sd100)
`define ERR_OVERFLOW      16'hfea2
`define ERR_NONE          16'h0000

// Queue geometry
`define ERRQ_DEPTH        16
`define ERRQ_AW           4
`define RESPQ_DEPTH       16
`define RESPQ_AW          4
`define CODE_W            16
`define RESP_W            8
`define ERRQ_FULL_CNT     5'h10
`define RESPQ_FULL_CNT    5'h10

// Reset values
`define ZERO8             8'h00
`define ZERO16            16'h0000
`define ONE_CNT5          5'h01
`define ZERO_CNT5         5'h00
`define ONE_PTR           4'h1

`endif

// >>> hw/status_event_reporting.v
// What this block does
// [R1] Status-byte query returns summary; query or clear empties
// [R2] Unused summary and event bits read zero
// [R3] Summary bit 2: unread error queue entries
// [R4] Summary bits 3,7 summarise questionable, operation
// [R5] Summary bit 4: response queue holds data
// [R6] Summary bit 5: event register nonzero
// [R7] Summary bit 6 is OR of others
// [R8] Event query returns flags; query or clear empties
// [R9] Event bit requests service only when enabled
// [R10] Event bit 0 on operations done
// [R11] Event bit 2 on query fault codes
// [R12] Event bit 3 on device fault codes
// [R13] Event bit 4 on execution fault codes
// [R14] Event bit 5 on command fault codes
// [R15] Event bit 7 set once at power-up
// [R16] Operation bit 1 while tuning
// [R17] Operation bits 5,6 armed and awaiting arm
// [R18] Operation bit 8 when new data readable
// [R19] Questionable bit 9 lock loss, rest zero
// [R20] Response queue FIFO, flushed by new command
// [R21] Error queue FIFO of sixteen entries
// [R22] Clear command empties error queue
// [R23] Overflow reports queue-overflow code
// [R24] Host loads and reads event enable mask
// [R25] Condition summaries are OR of register
// [R26] Full error queue drops new entries
`timescale 1ns/1ps
`default_nettype none
`include "status_event_map.vh"

module status_event_reporting (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // Host command strobes, one cycle each
    input  wire        new_command,
    input  wire        clear_status,
    input  wire        summary_query,
    input  wire        event_query,
    input  wire        next_error_query,
    input  wire        enable_write,
    input  wire [7:0]  enable_wdata,
    input  wire        enable_query,
    input  wire        oper_query,
    input  wire        ques_query,
    // Device events and conditions
    input  wire        operations_done,
    input  wire        error_valid,
    input  wire [15:0] error_code,
    input  wire        tuning_in_progress,
    input  wire        armed_waiting,
    input  wire        awaiting_arm,
    input  wire        data_ready,
    input  wire        lock_lost,
    // Response data from query execution
    input  wire        resp_valid,
    input  wire [7:0]  resp_data,
    input  wire        resp_read,
    // Answers to host
    output reg  [7:0]  status_summary_byte,
    output reg  [7:0]  reply_byte,
    output reg  [15:0] reply_word,
    output reg         reply_valid,
    output reg  [15:0] error_out,
    output reg         error_out_valid,
    output reg  [7:0]  resp_out,
    output reg         resp_out_valid,
    output reg         service_request
);

    reg  [7:0]  standard_event_flags;
    reg  [7:0]  event_enable_ff;
    reg  [15:0] operation_condition_flags;
    reg  [15:0] questionable_condition_flags;
    reg         power_up_flag;

    reg  [15:0] errq_mem [0:`ERRQ_DEPTH-1];
    reg  [3:0]  errq_rd_ff;
    reg  [3:0]  errq_wr_ff;
    reg  [4:0]  errq_cnt_ff;
    reg         errq_ovf_ff;
    reg  [7:0]  respq_mem [0:`RESPQ_DEPTH-1];
    reg  [3:0]  respq_rd_ff;
    reg  [3:0]  respq_wr_ff;
    reg  [4:0]  respq_cnt_ff;

    wire signed [15:0] code_s = error_code;
    wire        in_query  = (code_s >= `ERR_QUERY_LO)  && (code_s <= `ERR_QUERY_HI);
    wire        in_device = (code_s >= `ERR_DEVICE_LO) && (code_s <= `ERR_DEVICE_HI);
    wire        in_exec   = (code_s >= `ERR_EXEC_LO)   && (code_s <= `ERR_EXEC_HI);
    wire        in_cmd    = (code_s >= `ERR_CMD_LO)    && (code_s <= `ERR_CMD_HI);

    wire        errq_full   = (errq_cnt_ff == `ERRQ_FULL_CNT);
    wire        errq_empty  = (errq_cnt_ff == `ZERO_CNT5);
    wire        errq_pop    = next_error_query && !errq_empty && !clear_status;
    // Drop policy on full queue
    wire        errq_push   = error_valid && !clear_status && (!errq_full || errq_pop);
    wire        errq_ovf    = error_valid && !clear_status && errq_full && !errq_pop;

    wire        respq_full  = (respq_cnt_ff == `RESPQ_FULL_CNT);
    wire        respq_empty = (respq_cnt_ff == `ZERO_CNT5);
    wire        respq_flush = new_command || clear_status;
    wire        respq_pop   = resp_read && !respq_empty && !respq_flush;
    wire        respq_push  = resp_valid && !respq_flush && (!respq_full || respq_pop);

    // Occupancy after this cycle's push and pop
    wire [4:0]  nxt_errq_cnt  = errq_cnt_ff + {4'h0, errq_push} - {4'h0, errq_pop};
    wire [4:0]  nxt_respq_cnt = respq_cnt_ff + {4'h0, respq_push} - {4'h0, respq_pop};

    // Event bit sources
    reg  [7:0]  evt_set;
    always @* begin
        evt_set = `ZERO8;
        // [R10] Operations done
        evt_set[`EVT_DONE_BIT]   = operations_done;
        // [R11] Query fault
        evt_set[`EVT_QUERY_BIT]  = error_valid && in_query;
        // [R12] Device fault, includes overflow
        evt_set[`EVT_DEVICE_BIT] = (error_valid && in_device) || errq_ovf;
        // [R13] Execution fault
        evt_set[`EVT_EXEC_BIT]   = error_valid && in_exec;
        // [R14] Command fault
        evt_set[`EVT_CMD_BIT]    = error_valid && in_cmd;
        // [R15] Power-up once
        evt_set[`EVT_PWR_BIT]    = power_up_flag;
    end

    // [R3] [R4] [R5] [R6] [R7] [R25] Summary composition
    reg  [7:0]  nxt_summary;
    always @* begin
        nxt_summary = `ZERO8;
        nxt_summary[`SUM_ERRQ_BIT]  = !errq_empty;
        nxt_summary[`SUM_QUES_BIT]  = |questionable_condition_flags;
        nxt_summary[`SUM_RESP_BIT]  = !respq_empty;
        nxt_summary[`SUM_EVENT_BIT] = |standard_event_flags;
        nxt_summary[`SUM_OPER_BIT]  = |operation_condition_flags;
        // [R7] Master summary
        nxt_summary[`SUM_MASTER_BIT] = |nxt_summary;
    end

    // Summary register, cleared on query or clear; new causes win next cycle
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_summary_byte <= `ZERO8;
        end else begin
            // [R1] Clear on query or clear-status
            if (summary_query || clear_status) begin
                status_summary_byte <= `ZERO8;
            end else begin
                // [R2] Unused bits stay zero
                status_summary_byte <= nxt_summary;
            end
        end
    end

    // Power-up flag, one cycle after reset release
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            power_up_flag <= 1'b1;
        end else begin
            power_up_flag <= 1'b0;
        end
    end

    // Standard event register
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            standard_event_flags <= `ZERO8;
        end else begin
            // [R8] Clear on query or clear-status; set wins
            if (event_query || clear_status) begin
                standard_event_flags <= evt_set & `EVT_USED_MASK;
            end else begin
                // [R2] Bits 1 and 6 masked
                standard_event_flags <= (standard_event_flags | evt_set) & `EVT_USED_MASK;
            end
        end
    end

    // Enable mask and service request
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            event_enable_ff <= `ZERO8;
            service_request <= 1'b0;
        end else begin
            // [R24] Host writes mask
            if (enable_write) begin
                event_enable_ff <= enable_wdata;
            end
            // [R9] Gate by enable mask
            service_request <= |(standard_event_flags & event_enable_ff);
        end
    end

    // Condition register next values; unused bits stay zero
    reg  [15:0] nxt_oper;
    reg  [15:0] nxt_ques;
    always @* begin
        nxt_oper = `ZERO16;
        nxt_ques = `ZERO16;
        // [R16] Tuning
        nxt_oper[`OPER_TUNE_BIT]    = tuning_in_progress;
        // [R17] Armed and awaiting arm
        nxt_oper[`OPER_ARMED_BIT]   = armed_waiting;
        nxt_oper[`OPER_WAITARM_BIT] = awaiting_arm;
        // [R18] Data ready, may pulse
        nxt_oper[`OPER_DATA_BIT]    = data_ready;
        // [R19] Lock loss only
        nxt_ques[`QUES_LOCK_BIT]    = lock_lost;
    end

    // Condition registers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            operation_condition_flags    <= `ZERO16;
            questionable_condition_flags <= `ZERO16;
        end else begin
            operation_condition_flags    <= nxt_oper;
            questionable_condition_flags <= nxt_ques;
        end
    end

    // Reply next values, priority summary > event > enable > oper > ques
    reg  [7:0]  nxt_reply_byte;
    reg  [15:0] nxt_reply_word;
    always @* begin
        nxt_reply_byte = `ZERO8;
        nxt_reply_word = `ZERO16;
        if (summary_query) begin
            // [R1] Return summary
            nxt_reply_byte = status_summary_byte;
        end else if (event_query) begin
            // [R8] Return event flags
            nxt_reply_byte = standard_event_flags;
        end else if (enable_query) begin
            // [R24] Mask read back
            nxt_reply_byte = event_enable_ff;
        end else if (oper_query) begin
            nxt_reply_word = operation_condition_flags;
        end else if (ques_query) begin
            nxt_reply_word = questionable_condition_flags;
        end
    end

    // Register query replies
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reply_byte  <= `ZERO8;
            reply_word  <= `ZERO16;
            reply_valid <= 1'b0;
        end else begin
            reply_byte  <= nxt_reply_byte;
            reply_word  <= nxt_reply_word;
            reply_valid <= summary_query || event_query || enable_query
                           || oper_query || ques_query;
        end
    end

    // Error queue storage; the first dropped entry puts the overflow code in the newest slot
    always @(posedge ref_clk) begin
        // [R21] FIFO write
        if (errq_push) begin
            errq_mem[errq_wr_ff] <= error_code;
        end else if (errq_ovf && !errq_ovf_ff) begin
            // [R23] Overflow entry in newest slot
            errq_mem[errq_wr_ff - `ONE_PTR] <= `ERR_OVERFLOW;
        end
    end

    // Error read value; an empty queue answers with the no-error code
    reg  [15:0] nxt_error_out;
    always @* begin
        nxt_error_out = error_out;
        if (clear_status) begin
            nxt_error_out = `ERR_NONE;
        end else if (next_error_query) begin
            // [R21] One entry per query
            if (errq_empty) begin
                nxt_error_out = `ERR_NONE;
            end else begin
                nxt_error_out = errq_mem[errq_rd_ff];
            end
        end
    end

    // Error queue pointers
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            errq_rd_ff      <= 4'h0;
            errq_wr_ff      <= 4'h0;
            errq_cnt_ff     <= `ZERO_CNT5;
            error_out       <= `ERR_NONE;
            error_out_valid <= 1'b0;
        end else begin
            error_out_valid <= next_error_query && !clear_status;
            error_out       <= nxt_error_out;
            if (clear_status) begin
                // [R22] Empty queue
                errq_rd_ff  <= 4'h0;
                errq_wr_ff  <= 4'h0;
                errq_cnt_ff <= `ZERO_CNT5;
            end else begin
                if (errq_pop) begin
                    errq_rd_ff <= errq_rd_ff + `ONE_PTR;
                end
                if (errq_push) begin
                    errq_wr_ff <= errq_wr_ff + `ONE_PTR;
                end
                // [R26] Full queue keeps old entries
                errq_cnt_ff <= nxt_errq_cnt;
            end
        end
    end

    // Overflow marker: last stored slot is replaced by overflow code
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            errq_ovf_ff <= 1'b0;
        end else if (clear_status || (errq_empty && !errq_ovf)) begin
            errq_ovf_ff <= 1'b0;
        end else if (errq_ovf) begin
            // [R23] Overflow seen
            errq_ovf_ff <= 1'b1;
        end
    end

    // Response queue storage
    always @(posedge ref_clk) begin
        // [R20] FIFO write
        if (respq_push) begin
            respq_mem[respq_wr_ff] <= resp_data;
        end
    end

    // Response read value, held until the next pop
    reg  [7:0]  nxt_resp_out;
    always @* begin
        nxt_resp_out = resp_out;
        if (respq_pop) begin
            nxt_resp_out = respq_mem[respq_rd_ff];
        end
    end

    // Response queue pointers and output
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            respq_rd_ff    <= 4'h0;
            respq_wr_ff    <= 4'h0;
            respq_cnt_ff   <= `ZERO_CNT5;
            resp_out       <= `ZERO8;
            resp_out_valid <= 1'b0;
        end else begin
            resp_out_valid <= respq_pop;
            resp_out       <= nxt_resp_out;
            if (respq_flush) begin
                // [R20] Drop earlier unread results
                respq_rd_ff  <= 4'h0;
                respq_wr_ff  <= 4'h0;
                respq_cnt_ff <= `ZERO_CNT5;
            end else begin
                if (respq_pop) begin
                    respq_rd_ff <= respq_rd_ff + `ONE_PTR;
                end
                if (respq_push) begin
                    respq_wr_ff <= respq_wr_ff + `ONE_PTR;
                end
                respq_cnt_ff <= nxt_respq_cnt;
            end
        end
    end

endmodule

`default_nettype wire

// >>> verif/status_event_chk.sv
`timescale 1ns/1ps
`default_nettype none
module status_event_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Host strobes
    input wire logic        new_command,
    input wire logic        clear_status,
    input wire logic        summary_query,
    input wire logic        event_query,
    input wire logic        enable_write,
    input wire logic [7:0]  enable_wdata,
    input wire logic        enable_query,
    input wire logic        oper_query,
    input wire logic        resp_read,
    // Conditions
    input wire logic        tuning_in_progress,
    input wire logic        armed_waiting,
    input wire logic        awaiting_arm,
    input wire logic        data_ready,
    // Answers
    input wire logic [7:0]  status_summary_byte,
    input wire logic [7:0]  reply_byte,
    input wire logic [15:0] reply_word,
    input wire logic        reply_valid,
    input wire logic        resp_out_valid,
    input wire logic        service_request
);
    wire [15:0] oper_now = {7'h00, data_ready, 1'b0, awaiting_arm, armed_waiting, 3'h0,
                            tuning_in_progress, 1'b0};
    wire        above_oper = summary_query | event_query | enable_query;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_summary_unused: assert property (status_summary_byte[1:0] == 2'h0)
        else $error("summary byte spare bits set");
    a_master_summary: assert property (
        status_summary_byte[6] == |{status_summary_byte[7], status_summary_byte[5:2]})
        else $error("master summary bit disagrees");
    a_summary_reply: assert property (summary_query |=>
        reply_valid && reply_byte == $past(status_summary_byte))
        else $error("summary reply wrong");
    a_summary_cleared: assert property (summary_query |=> status_summary_byte == 8'h00)
        else $error("summary not cleared by query");
    a_event_unused: assert property (event_query && !summary_query |=>
        reply_valid && !reply_byte[1] && !reply_byte[6])
        else $error("event reply spare bits set");
    a_oper_reply: assert property (
        oper_query && !above_oper && $stable(oper_now) |=> reply_word == $past(oper_now))
        else $error("operation reply wrong");
    a_resp_flush: assert property (new_command ##1 resp_read |=> !resp_out_valid)
        else $error("response survived new command");
    a_srq_masked: assert property (
        enable_write && enable_wdata == 8'h00 ##1 !enable_write [*2] |=> !service_request)
        else $error("service request with empty mask");
    a_oper_summary: assert property (
        (tuning_in_progress && !summary_query && !clear_status) [*3] |-> status_summary_byte[7])
        else $error("operation summary bit missing");

    cover property (summary_query ##1 reply_valid);
    cover property (service_request);
    cover property (resp_out_valid);
endmodule

bind status_event_reporting status_event_chk status_event_chk_i (
    .ref_clk, .rst, .new_command, .clear_status, .summary_query, .event_query,
    .enable_write, .enable_wdata, .enable_query, .oper_query, .resp_read,
    .tuning_in_progress, .armed_waiting, .awaiting_arm, .data_ready,
    .status_summary_byte, .reply_byte, .reply_word, .reply_valid, .resp_out_valid,
    .service_request
);
`default_nettype wire

// >>> verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic       ref_clk,
    // Command strobes and mask value
    output var  logic [9:0] strobe,
    output var  logic [7:0] mask_data
);
    initial begin
        strobe = 10'h000;
        mask_data = 8'h00;
    end

    // Strobes hold from each call until the next call changes them
    task automatic cyc(input logic [9:0] s, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        strobe = s;
        mask_data = s[5] ? d : ~d;
    endtask
endmodule
`default_nettype wire

// >>> verif/status_event_reporting_test.sv
`timescale 1ns/1ps
`default_nettype none
module status_event_reporting_test;
    logic        ref_clk, rst, operations_done, error_valid, resp_valid;
    logic        tuning_in_progress, armed_waiting, awaiting_arm, data_ready, lock_lost;
    logic [15:0] error_code;
    logic [7:0]  resp_data;
    wire  [9:0]  strobe;
    wire  [7:0]  mask_data, status_summary_byte, reply_byte, resp_out;
    wire  [15:0] reply_word, error_out;
    wire         reply_valid, error_out_valid, resp_out_valid, service_request;
    int          n_errors = 0;
    int          compares = 0;
    logic [15:0] exp_code;
    // Entry valid, error code, expected event flags
    logic [24:0] rows [10] = '{25'h0000001, 25'h1fe0d04, 25'h1fe7004, 25'h1fe7108,
        25'h1fed408, 25'h1fed510, 25'h1ff3810, 25'h1ff3920, 25'h1ff9c20, 25'h1fc1900};

    host_model host_model_i (.ref_clk, .strobe, .mask_data);
    status_event_reporting status_event_reporting_i (
        .ref_clk, .rst, .new_command(strobe[0]), .clear_status(strobe[1]),
        .summary_query(strobe[2]), .event_query(strobe[3]), .next_error_query(strobe[4]),
        .enable_write(strobe[5]), .enable_wdata(mask_data), .enable_query(strobe[6]),
        .oper_query(strobe[7]), .ques_query(strobe[8]), .resp_read(strobe[9]),
        .operations_done, .error_valid, .error_code, .tuning_in_progress, .armed_waiting,
        .awaiting_arm, .data_ready, .lock_lost, .resp_valid, .resp_data,
        .status_summary_byte, .reply_byte, .reply_word, .reply_valid, .error_out,
        .error_out_valid, .resp_out, .resp_out_valid, .service_request);

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run;
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One strobe cycle, then n idle cycles
    task automatic go(input logic [9:0] s, input int n);
        host_model_i.cyc(s, 8'h00);
        repeat (n) host_model_i.cyc(10'h000, 8'h00);
    endtask

    // Error entry when v is set, operations done otherwise
    task automatic push(input logic v, input logic [15:0] c);
        error_valid = v;
        operations_done = ~v;
        error_code = c;
        host_model_i.cyc(10'h000, 8'h00);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        complete_run();
    end

    initial begin
        {operations_done, error_valid, resp_valid, lock_lost} = 4'h0;
        {tuning_in_progress, armed_waiting, awaiting_arm, data_ready} = 4'h0;
        error_code = 16'h0000;
        resp_data = 8'h00;
        rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        go(10'h000, 2);
        go(10'h004, 1);
        chk("power-up summary", 16'h0060, {8'h00, reply_byte});
        go(10'h008, 1);
        chk("power-up flags", 16'h0080, {8'h00, reply_byte});
        go(10'h008, 1);
        chk("flags after read", 16'h0000, {8'h00, reply_byte});
        go(10'h000, 1);
        chk("summary idle", 16'h0000, {8'h00, status_summary_byte});
        foreach (rows[i]) begin
            go(10'h002, 1);
            push(rows[i][24], rows[i][23:8]);
            {operations_done, error_valid} = 2'h0;
            go(10'h008, 1);
            chk("event flags", 16'(rows[i][7:0]), 16'(reply_byte));
            go(10'h010, 1);
            chk("error entry", rows[i][23:8], error_out);
            chk("error valid", 16'h0001, 16'(error_out_valid));
        end
        host_model_i.cyc(10'h020, 8'h04);
        push(1'b1, 16'hfe70);
        error_valid = 1'b0;
        go(10'h040, 1);
        chk("enable readback", 16'h0004, {8'h00, reply_byte});
        chk("service request", 16'h0001, {15'h0000, service_request});
        go(10'h002, 2);
        chk("service after clear", 16'h0000, {15'h0000, service_request});
        host_model_i.cyc(10'h020, 8'h20);
        push(1'b1, 16'hfe70);
        error_valid = 1'b0;
        go(10'h000, 2);
        chk("service masked", 16'h0000, {15'h0000, service_request});
        go(10'h002, 1);
        for (int k = 0; k < 17; k++) push(1'b1, 16'hff9c - k[15:0]);
        error_valid = 1'b0;
        chk("queue flag set", 16'h0004, {8'h00, status_summary_byte & 8'h04});
        for (int k = 0; k < 17; k++) begin
            exp_code = k < 15 ? 16'hff9c - k[15:0] : (k == 15 ? 16'hfea2 : 16'h0000);
            go(10'h010, 1);
            chk("queued entry", exp_code, error_out);
        end
        chk("queue flag clear", 16'h0000, {8'h00, status_summary_byte & 8'h04});
        push(1'b1, 16'hff38);
        error_valid = 1'b0;
        go(10'h002, 0);
        go(10'h010, 1);
        chk("cleared queue", 16'h0000, error_out);
        go(10'h001, 1);
        resp_valid = 1'b1;
        resp_data = 8'ha1;
        host_model_i.cyc(10'h000, 8'h00);
        resp_data = 8'hb2;
        host_model_i.cyc(10'h000, 8'h00);
        resp_valid = 1'b0;
        go(10'h000, 1);
        chk("response flag", 16'h0010, {8'h00, status_summary_byte & 8'h10});
        host_model_i.cyc(10'h200, 8'h00);
        host_model_i.cyc(10'h200, 8'h00);
        chk("first response", 16'h01a1, {7'h00, resp_out_valid, resp_out});
        host_model_i.cyc(10'h000, 8'h00);
        chk("second response", 16'h01b2, {7'h00, resp_out_valid, resp_out});
        resp_valid = 1'b1;
        resp_data = 8'hc3;
        host_model_i.cyc(10'h001, 8'h00);
        resp_valid = 1'b0;
        go(10'h200, 1);
        chk("flushed response", 16'h0000, {15'h0000, resp_out_valid});
        {tuning_in_progress, armed_waiting, awaiting_arm, data_ready, lock_lost} = 5'h1f;
        go(10'h080, 1);
        chk("operation word", 16'h0162, reply_word);
        go(10'h100, 1);
        chk("questionable word", 16'h0200, reply_word);
        chk("condition summary", 16'h00c8, {8'h00, status_summary_byte & 8'hc8});
        host_model_i.cyc(10'h020, 8'h00);
        go(10'h000, 3);
        complete_run();
    end
endmodule
`default_nettype wire
